// >>> bench/acrb_host_model.sv
module acrb_host_model
    import acrb_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic serial_data_in,
    output logic serial_clk_out,
    output logic chip_select_n_out,
    output logic serial_data_out
);
    timeunit 1ns;
    timeprecision 1ns;
    // ==========================================================
    // Mode 0 serial master, 800 ns clock only inside frames
    // ==========================================================
    initial begin
        serial_clk_out = 1'b0;
        chip_select_n_out = 1'b1;
        serial_data_out = 1'b1;
    end
    task automatic half;
        repeat (4) @(negedge core_clk_in);
    endtask : half
    task automatic select(input logic on);
        half();
        chip_select_n_out = ~on;
        if (!on) serial_data_out = ~serial_data_out;
        half();
    endtask : select
    task automatic bit_io(input logic b, output logic r);
        serial_data_out = b;
        half();
        serial_clk_out = 1'b1;
        half();
        r = serial_data_in;
        serial_clk_out = 1'b0;
    endtask : bit_io
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
    endtask : xfer
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        logic [7:0] r;
        select(1'b1);
        xfer({CMD_REG_WRITE, 1'b0, a}, r);
        xfer(d, r);
        select(1'b0);
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [7:0] r);
        select(1'b1);
        xfer({CMD_REG_READ, 1'b0, a}, r);
        xfer(8'hFF, r);
        select(1'b0);
    endtask : rd
endmodule : acrb_host_model

// >>> bench/acrb_register_bank_asserts.sv
module acrb_register_bank_asserts
    import acrb_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic sys_rst_in,
    input wire logic clock_source_strap_in,
    input wire logic clock_pin_oe_n_out,
    input wire logic scan_or_fixed_select_out,
    input wire logic external_converter_path_select_out,
    input wire logic [4:0] monitor_external_path_out,
    input wire logic header_on_command_read_out,
    input wire logic header_on_direct_read_out,
    input wire logic [1:0] conversion_speed_select_out,
    input wire logic [16:0] nominal_rate_sps_out,
    input wire logic [3:0] positive_input_select_out,
    input wire logic [3:0] negative_input_select_out,
    input wire logic [7:0] pair_scan_enable_out,
    input wire logic [15:0] single_input_scan_enable_out,
    input wire logic [7:0] monitor_scan_enable_out,
    input wire logic scan_pointer_reset_out
);
    timeunit 1ns;
    timeprecision 1ns;
    // ==========================================================
    // Output relations
    // ==========================================================
    localparam logic [16:0] RT [0:7] = '{SPS_SCAN_0, SPS_SCAN_1, SPS_SCAN_2, SPS_SCAN_3,
        SPS_FIXED_0, SPS_FIXED_1, SPS_FIXED_2, SPS_FIXED_3};
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (sys_rst_in);
    sequence s_strap_held;
        clock_source_strap_in [*6];
    endsequence
    property p_strap; s_strap_held |-> clock_pin_oe_n_out; endproperty
    a_strap: assert property (p_strap) else $error("clock pin driven with strap high");
    property p_direct; header_on_direct_read_out |-> !scan_or_fixed_select_out; endproperty
    a_direct: assert property (p_direct) else $error("direct header in fixed mode");
    property p_cmd; header_on_command_read_out; endproperty
    a_cmd: assert property (p_cmd) else $error("command header missing");
    property p_fixed; scan_or_fixed_select_out |-> (pair_scan_enable_out == 8'h00)
        && (single_input_scan_enable_out == 16'h0000) && (monitor_scan_enable_out == 8'h00); endproperty
    a_fixed: assert property (p_fixed) else $error("scan enables active in fixed mode");
    property p_scan; !scan_or_fixed_select_out |-> {positive_input_select_out, negative_input_select_out} == 8'h00;
    endproperty
    a_scan: assert property (p_scan) else $error("fixed selects active in scan mode");
    property p_path; monitor_external_path_out == {4'h0, external_converter_path_select_out}; endproperty
    a_path: assert property (p_path) else $error("monitor path wrong");
    property p_rate; nominal_rate_sps_out == RT[{scan_or_fixed_select_out, conversion_speed_select_out}];
    endproperty
    a_rate: assert property (p_rate) else $error("nominal rate wrong");
    property p_pulse; $rose(scan_pointer_reset_out) |=> !scan_pointer_reset_out; endproperty
    a_pulse: assert property (p_pulse) else $error("pointer reset not one cycle");
endmodule : acrb_register_bank_asserts

bind acrb_register_bank acrb_register_bank_asserts u_acrb_register_bank_asserts (.core_clk_in, .sys_rst_in,
    .clock_source_strap_in, .clock_pin_oe_n_out, .scan_or_fixed_select_out, .external_converter_path_select_out,
    .monitor_external_path_out, .header_on_command_read_out, .header_on_direct_read_out,
    .conversion_speed_select_out, .nominal_rate_sps_out, .positive_input_select_out, .negative_input_select_out,
    .pair_scan_enable_out, .single_input_scan_enable_out, .monitor_scan_enable_out, .scan_pointer_reset_out);

// >>> bench/adc_config_register_bank_bench.sv
module adc_config_register_bank_bench
    import acrb_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [7:0] SIG = 8'hC6; // Arbitrary value
    localparam logic [7:0] RV [0:9] = '{8'h0A, 8'h83, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'hFF, 8'hC3, SIG};
    localparam logic [7:0] MV [0:6] = '{8'h81, 8'h0F, 8'hF0, 8'h21, 8'h0F, 8'h55, 8'hEE};
    logic core_clk_in, sys_rst_in, clock_source_strap_in, serial_clk_in, chip_select_n_in, serial_data_in;
    logic serial_data_out, serial_data_oe_n_out, clock_pin_oe_n_out, scan_or_fixed_select_out;
    logic external_converter_path_select_out, chop_enable_out, header_on_command_read_out, header_on_direct_read_out;
    logic low_power_kind_select_out, scan_pointer_reset_out;
    logic [1:0] bias_current_level_out, conversion_speed_select_out;
    logic [2:0] channel_switch_wait_out;
    logic [3:0] positive_input_select_out, negative_input_select_out;
    logic [4:0] monitor_external_path_out;
    logic [7:0] port_pin_in, port_pin_out, port_pin_oe_n_out, pair_scan_enable_out, monitor_scan_enable_out, r;
    logic [15:0] single_input_scan_enable_out;
    logic [16:0] nominal_rate_sps_out;
    int err_total = 0;
    int tests_run = 0;
    int pulses = 0;
    // Released data line toggles every cycle so a stale value cannot pass
    wire logic miso = serial_data_oe_n_out ? core_clk_in : serial_data_out;
    acrb_register_bank #(.SIGNATURE(SIG), .PORT_WIDTH(8)) u_acrb_register_bank (.*);
    acrb_host_model u_acrb_host_model (.core_clk_in(core_clk_in), .serial_data_in(miso),
        .serial_clk_out(serial_clk_in), .chip_select_n_out(chip_select_n_in), .serial_data_out(serial_data_in));
    initial begin
        core_clk_in = 1'b0;
        forever #50 core_clk_in = ~core_clk_in;
    end
    always @(posedge core_clk_in) if (scan_pointer_reset_out === 1'b1) pulses++;
    task automatic chk(input string nm, input logic [16:0] seen, input logic [16:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic rc(input logic [3:0] a, input logic [7:0] e);
        u_acrb_host_model.rd(a, r);
        chk($sformatf("read %h", a), r, e);
    endtask : rc
    task automatic complete_run;
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : complete_run
    // ==========================================================
    // Scenarios
    // ==========================================================
    initial begin
        sys_rst_in = 1'b1;
        clock_source_strap_in = 1'b0;
        port_pin_in = 8'hC3;
        repeat (16) @(negedge core_clk_in);
        sys_rst_in = 1'b0;
        repeat (8) @(negedge core_clk_in);
        chk("clock pin", clock_pin_oe_n_out, 1'b0);
        for (int a = 0; a < 10; a++) rc(a[3:0], RV[a]);
        u_acrb_host_model.wr(ADDR_CONVERSION_CONFIGURATION, 8'h5E);
        chk("conversion", {low_power_kind_select_out, channel_switch_wait_out, bias_current_level_out,
            conversion_speed_select_out}, 8'h5E);
        chk("scan rate", nominal_rate_sps_out, SPS_SCAN_2);
        u_acrb_host_model.wr(ADDR_FIXED_CHANNEL_SELECT, 8'hA5);
        chk("selects in scan", {positive_input_select_out, negative_input_select_out}, 8'h00);
        u_acrb_host_model.wr(ADDR_GENERAL_CONFIGURATION, 8'h30);
        chk("selects", {positive_input_select_out, negative_input_select_out}, 8'hA5);
        chk("general", {scan_or_fixed_select_out, external_converter_path_select_out, monitor_external_path_out,
            clock_pin_oe_n_out, header_on_direct_read_out}, 9'h186);
        chk("fixed rate", nominal_rate_sps_out, SPS_FIXED_2);
        chk("enables", {pair_scan_enable_out, single_input_scan_enable_out}, 24'h0);
        u_acrb_host_model.wr(ADDR_GENERAL_CONFIGURATION, 8'h4E);
        chk("scan chop", {scan_or_fixed_select_out, chop_enable_out, header_on_direct_read_out,
            clock_pin_oe_n_out, header_on_command_read_out}, 5'h0D);
        u_acrb_host_model.wr(ADDR_GENERAL_CONFIGURATION, 8'h4A);
        u_acrb_host_model.select(1'b1);
        for (int i = 0; i < 3; i++) u_acrb_host_model.bit_io(1'b1, r[0]);
        repeat (300) @(negedge core_clk_in);
        u_acrb_host_model.xfer({CMD_REG_READ, 1'b0, ADDR_CONVERSION_CONFIGURATION}, r);
        u_acrb_host_model.xfer(8'hFF, r);
        u_acrb_host_model.select(1'b0);
        chk("after idle timeout", r, 8'h5E);
        u_acrb_host_model.select(1'b1);
        u_acrb_host_model.xfer({CMD_REG_WRITE, 1'b1, ADDR_SCAN_PAIR_ENABLES}, r);
        for (int i = 0; i < 7; i++) u_acrb_host_model.xfer(MV[i], r);
        u_acrb_host_model.xfer({CMD_REG_READ, 1'b0, ADDR_SCAN_PAIR_ENABLES}, r);
        u_acrb_host_model.xfer(8'hFF, r);
        u_acrb_host_model.select(1'b0);
        chk("command after last", r, 8'h81);
        chk("scan outputs", {pair_scan_enable_out, single_input_scan_enable_out, monitor_scan_enable_out},
            32'h81F00F21);
        chk("port", {port_pin_oe_n_out, port_pin_out}, 16'h0F55);
        chk("pointer pulses", pulses, 4);
        rc(ADDR_DEVICE_SIGNATURE, SIG);
        u_acrb_host_model.wr(4'hC, 8'hFF);
        rc(4'hC, 8'h00);
        clock_source_strap_in = 1'b1;
        repeat (8) @(negedge core_clk_in);
        chk("strap", clock_pin_oe_n_out, 1'b1);
        complete_run();
    end
    initial begin
        repeat (20000) @(posedge core_clk_in);
        err_total++;
        complete_run();
    end
endmodule : adc_config_register_bank_bench

// >>> hw/acrb_pkg.sv
package acrb_pkg;

    // ==========================================================
    // Register addresses
    // ==========================================================
    localparam logic [3:0] ADDR_GENERAL_CONFIGURATION = 4'h0;
    localparam logic [3:0] ADDR_CONVERSION_CONFIGURATION = 4'h1;
    localparam logic [3:0] ADDR_FIXED_CHANNEL_SELECT = 4'h2;
    localparam logic [3:0] ADDR_SCAN_PAIR_ENABLES = 4'h3;
    localparam logic [3:0] ADDR_SCAN_SINGLE_LOW_ENABLES = 4'h4;
    localparam logic [3:0] ADDR_SCAN_SINGLE_HIGH_ENABLES = 4'h5;
    localparam logic [3:0] ADDR_SCAN_MONITOR_ENABLES = 4'h6;
    localparam logic [3:0] ADDR_PORT_DIRECTION = 4'h7;
    localparam logic [3:0] ADDR_PORT_LEVEL = 4'h8;
    localparam logic [3:0] ADDR_DEVICE_SIGNATURE = 4'h9;
    localparam int REG_COUNT = 9;

    // ==========================================================
    // Reset values
    // ==========================================================
    localparam logic [7:0] RST_GENERAL_CONFIGURATION = 8'h0A;
    localparam logic [7:0] RST_CONVERSION_CONFIGURATION = 8'h83;
    localparam logic [7:0] RST_FIXED_CHANNEL_SELECT = 8'h00;
    localparam logic [7:0] RST_SCAN_PAIR_ENABLES = 8'h00;
    localparam logic [7:0] RST_SCAN_SINGLE_LOW_ENABLES = 8'hFF;
    localparam logic [7:0] RST_SCAN_SINGLE_HIGH_ENABLES = 8'hFF;
    localparam logic [7:0] RST_SCAN_MONITOR_ENABLES = 8'h00;
    localparam logic [7:0] RST_PORT_DIRECTION = 8'hFF;
    localparam logic [7:0] RST_PORT_LEVEL = 8'h00;

    // ==========================================================
    // Field positions
    // ==========================================================
    localparam int GC_IDLE_TIMEOUT_BIT = 6;
    localparam int GC_MODE_BIT = 5;
    localparam int GC_PATH_BIT = 4;
    localparam int GC_CLKOUT_BIT = 3;
    localparam int GC_CHOP_BIT = 2;
    localparam int GC_HEADER_BIT = 1;
    localparam int CC_LOW_POWER_BIT = 7;
    localparam int CC_WAIT_LSB = 4;
    localparam int CC_BIAS_LSB = 2;
    localparam int CC_SPEED_LSB = 0;
    localparam int FC_POS_LSB = 4;
    localparam int FC_NEG_LSB = 0;
    localparam int MON_OFFSET_BIT = 0;

    // ==========================================================
    // Command byte
    // ==========================================================
    localparam int CMD_CODE_LSB = 5;
    localparam int CMD_MULTI_BIT = 4;
    localparam logic [2:0] CMD_REG_READ = 3'h2;
    localparam logic [2:0] CMD_REG_WRITE = 3'h3;

    // ==========================================================
    // Timing
    // ==========================================================
    localparam int IDLE_TIMEOUT_LONG_CYCLES = 4096;
    localparam int IDLE_TIMEOUT_SHORT_CYCLES = 256;

    // Nominal rates at 16 MHz, no wait, no chopping
    localparam logic [16:0] SPS_SCAN_3 = 17'd23739;
    localparam logic [16:0] SPS_SCAN_2 = 17'd15123;
    localparam logic [16:0] SPS_SCAN_1 = 17'd6168;
    localparam logic [16:0] SPS_SCAN_0 = 17'd1831;
    localparam logic [16:0] SPS_FIXED_3 = 17'd125000;
    localparam logic [16:0] SPS_FIXED_2 = 17'd31250;
    localparam logic [16:0] SPS_FIXED_1 = 17'd7813;
    localparam logic [16:0] SPS_FIXED_0 = 17'd1953;

    typedef enum logic [1:0] {
        ACRB_SER_CMD = 2'b00,
        ACRB_SER_WRITE = 2'b01,
        ACRB_SER_READ = 2'b11
    } acrb_ser_state_t;

endpackage : acrb_pkg

// >>> hw/acrb_register_bank.sv
module acrb_register_bank
    import acrb_pkg::*;
#(
    parameter logic [7:0] SIGNATURE = 8'h5A, // Arbitrary value
    parameter int PORT_WIDTH = 8
) (
    input wire logic core_clk_in,
    input wire logic sys_rst_in,
    input wire logic serial_clk_in,
    input wire logic chip_select_n_in,
    input wire logic serial_data_in,
    output logic serial_data_out,
    output logic serial_data_oe_n_out,
    input wire logic clock_source_strap_in,
    output logic clock_pin_oe_n_out,
    input wire logic [PORT_WIDTH-1:0] port_pin_in,
    output logic [PORT_WIDTH-1:0] port_pin_out,
    output logic [PORT_WIDTH-1:0] port_pin_oe_n_out,
    output logic scan_or_fixed_select_out,
    output logic external_converter_path_select_out,
    output logic [4:0] monitor_external_path_out,
    output logic chop_enable_out,
    output logic header_on_command_read_out,
    output logic header_on_direct_read_out,
    output logic low_power_kind_select_out,
    output logic [2:0] channel_switch_wait_out,
    output logic [1:0] bias_current_level_out,
    output logic [1:0] conversion_speed_select_out,
    output logic [16:0] nominal_rate_sps_out,
    output logic [3:0] positive_input_select_out,
    output logic [3:0] negative_input_select_out,
    output logic [7:0] pair_scan_enable_out,
    output logic [15:0] single_input_scan_enable_out,
    output logic [7:0] monitor_scan_enable_out,
    output logic scan_pointer_reset_out
);

    // ==========================================================
    // Input synchronisers
    // ==========================================================
    localparam int SYNC_WIDTH = 4 + PORT_WIDTH;
    logic [SYNC_WIDTH-1:0] raw_in;
    logic [SYNC_WIDTH-1:0] sync1_q;
    logic [SYNC_WIDTH-1:0] sync2_q;
    logic [SYNC_WIDTH-1:0] sync3_q;
    logic [SYNC_WIDTH-1:0] clean_q;

    assign raw_in = {port_pin_in, clock_source_strap_in, serial_data_in, chip_select_n_in, serial_clk_in};

    genvar gi;
    generate
        for (gi = 0; gi < SYNC_WIDTH; gi++) begin : g_sync
            // Idle levels of the serial pins after reset: clock low, select high
            localparam logic RST_LEVEL = (gi == 1) ? 1'b1 : 1'b0;
            always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
                if (sys_rst_in) begin
                    sync1_q[gi] <= RST_LEVEL;
                    sync2_q[gi] <= RST_LEVEL;
                    sync3_q[gi] <= RST_LEVEL;
                    clean_q[gi] <= RST_LEVEL;
                end else begin
                    sync1_q[gi] <= raw_in[gi];
                    sync2_q[gi] <= sync1_q[gi];
                    sync3_q[gi] <= sync2_q[gi];
                    if (sync2_q[gi] == sync3_q[gi]) begin
                        clean_q[gi] <= sync3_q[gi];
                    end
                end
            end
        end
    endgenerate

    logic sclk_prev_q;
    logic sclk_rise;
    logic sclk_fall;
    logic cs_active;
    logic din_level;
    logic strap_level;
    logic [PORT_WIDTH-1:0] pin_level;

    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            sclk_prev_q <= 1'b0;
        end else begin
            sclk_prev_q <= clean_q[0];
        end
    end

    assign cs_active = ~clean_q[1];
    assign sclk_rise = cs_active & clean_q[0] & ~sclk_prev_q;
    assign sclk_fall = cs_active & ~clean_q[0] & sclk_prev_q;
    assign din_level = clean_q[2];
    assign strap_level = clean_q[3];
    assign pin_level = clean_q[SYNC_WIDTH-1:4];

    // ==========================================================
    // Register storage
    // ==========================================================
    logic [7:0] regs_q [REG_COUNT];
    logic [7:0] gen_cfg;
    logic [7:0] conv_cfg;

    assign gen_cfg = regs_q[ADDR_GENERAL_CONFIGURATION];
    assign conv_cfg = regs_q[ADDR_CONVERSION_CONFIGURATION];

    function automatic logic [7:0] reset_value(input int idx);
        unique case (idx)
            0: reset_value = RST_GENERAL_CONFIGURATION;
            1: reset_value = RST_CONVERSION_CONFIGURATION;
            2: reset_value = RST_FIXED_CHANNEL_SELECT;
            3: reset_value = RST_SCAN_PAIR_ENABLES;
            4: reset_value = RST_SCAN_SINGLE_LOW_ENABLES;
            5: reset_value = RST_SCAN_SINGLE_HIGH_ENABLES;
            6: reset_value = RST_SCAN_MONITOR_ENABLES;
            7: reset_value = RST_PORT_DIRECTION;
            default: reset_value = RST_PORT_LEVEL;
        endcase
    endfunction : reset_value

    // Read view: level register shows the pins, signature is fixed, pointers above the signature read zero
    function automatic logic [7:0] read_value(input logic [3:0] addr);
        if (addr == ADDR_PORT_LEVEL) begin
            read_value = 8'(pin_level);
        end else if (addr == ADDR_DEVICE_SIGNATURE) begin
            read_value = SIGNATURE;
        end else if (addr < ADDR_PORT_LEVEL) begin
            read_value = regs_q[addr];
        end else begin
            read_value = 8'h00;
        end
    endfunction : read_value

    // ==========================================================
    // Serial command engine
    // ==========================================================
    acrb_ser_state_t state_q;
    logic [2:0] bit_cnt_q;
    logic [7:0] rx_q;
    logic [7:0] byte_in;
    logic [3:0] ptr_q;
    logic multi_q;
    logic [7:0] tx_q;
    logic [12:0] idle_cnt_q;
    logic [12:0] idle_limit;
    logic idle_expired;
    logic byte_done;
    logic last_access;
    logic wr_strobe;

    assign byte_in = {rx_q[6:0], din_level};
    assign byte_done = sclk_rise && (bit_cnt_q == 3'h7);
    assign last_access = ~multi_q || (ptr_q == ADDR_DEVICE_SIGNATURE);
    assign wr_strobe = byte_done && (state_q == ACRB_SER_WRITE);

    assign idle_limit = gen_cfg[GC_IDLE_TIMEOUT_BIT] ? 13'(IDLE_TIMEOUT_SHORT_CYCLES)
                                                     : 13'(IDLE_TIMEOUT_LONG_CYCLES);
    assign idle_expired = (idle_cnt_q >= idle_limit);

    // Idle timer counts core cycles without a serial clock edge
    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            idle_cnt_q <= 13'h0000;
        end else if (sclk_rise || sclk_fall || !cs_active) begin
            idle_cnt_q <= 13'h0000;
        end else if (!idle_expired) begin
            idle_cnt_q <= idle_cnt_q + 13'h0001;
        end
    end

    // Timeout or deselect clears only the serial state; an edge ending the gap is a first bit
    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            state_q <= ACRB_SER_CMD;
            bit_cnt_q <= 3'h0;
            rx_q <= 8'h00;
            ptr_q <= 4'h0;
            multi_q <= 1'b0;
        end else if (!cs_active || (idle_expired && !sclk_rise)) begin
            state_q <= ACRB_SER_CMD;
            bit_cnt_q <= 3'h0;
            rx_q <= 8'h00;
        end else if (sclk_rise) begin
            bit_cnt_q <= bit_cnt_q + 3'h1;
            rx_q <= byte_in;
            if (byte_done) begin
                unique case (state_q)
                    ACRB_SER_CMD: begin
                        ptr_q <= byte_in[3:0];
                        multi_q <= byte_in[CMD_MULTI_BIT];
                        if (byte_in[7:CMD_CODE_LSB] == CMD_REG_WRITE) begin
                            state_q <= ACRB_SER_WRITE;
                        end else if (byte_in[7:CMD_CODE_LSB] == CMD_REG_READ) begin
                            state_q <= ACRB_SER_READ;
                        end
                    end
                    ACRB_SER_WRITE, ACRB_SER_READ: begin
                        if (last_access) begin
                            state_q <= ACRB_SER_CMD;
                        end else begin
                            ptr_q <= ptr_q + 4'h1;
                        end
                    end
                    default: begin
                        state_q <= ACRB_SER_CMD;
                    end
                endcase
            end
        end
    end

    // Read data: load when a read command or a non-final read byte completes, shift out on falling edges
    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            tx_q <= 8'h00;
            serial_data_out <= 1'b0;
        end else if (!cs_active) begin
            tx_q <= 8'h00;
            serial_data_out <= 1'b0;
        end else if (byte_done && state_q == ACRB_SER_CMD && byte_in[7:CMD_CODE_LSB] == CMD_REG_READ) begin
            tx_q <= read_value(byte_in[3:0]);
        end else if (byte_done && state_q == ACRB_SER_READ && !last_access) begin
            tx_q <= read_value(ptr_q + 4'h1);
        end else if (sclk_fall) begin
            serial_data_out <= tx_q[7];
            tx_q <= {tx_q[6:0], 1'b0};
        end
    end

    assign serial_data_oe_n_out = ~cs_active;

    // Register writes; the signature and reserved pointers have no storage
    generate
        for (gi = 0; gi < REG_COUNT; gi++) begin : g_regs
            always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
                if (sys_rst_in) begin
                    regs_q[gi] <= reset_value(gi);
                end else if (wr_strobe && ptr_q == 4'(gi)) begin
                    regs_q[gi] <= byte_in;
                end
            end
        end
    endgenerate

    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            scan_pointer_reset_out <= 1'b0;
        end else begin
            scan_pointer_reset_out <= wr_strobe && ptr_q >= ADDR_SCAN_PAIR_ENABLES
                                      && ptr_q <= ADDR_SCAN_MONITOR_ENABLES;
        end
    end

    // ==========================================================
    // Configuration outputs
    // ==========================================================
    logic fixed_mode;

    assign fixed_mode = gen_cfg[GC_MODE_BIT];

    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            scan_or_fixed_select_out <= 1'b0;
            external_converter_path_select_out <= 1'b0;
            monitor_external_path_out <= 5'h00;
            chop_enable_out <= 1'b0;
            header_on_command_read_out <= 1'b1;
            header_on_direct_read_out <= 1'b0;
            clock_pin_oe_n_out <= 1'b1;
        end else begin
            scan_or_fixed_select_out <= fixed_mode;
            external_converter_path_select_out <= gen_cfg[GC_PATH_BIT];
            // Only the offset reading may take the external path
            monitor_external_path_out <= {4'h0, gen_cfg[GC_PATH_BIT]};
            chop_enable_out <= gen_cfg[GC_CHOP_BIT];
            header_on_command_read_out <= 1'b1;
            header_on_direct_read_out <= ~fixed_mode & gen_cfg[GC_HEADER_BIT];
            clock_pin_oe_n_out <= ~(gen_cfg[GC_CLKOUT_BIT] & ~strap_level);
        end
    end

    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            low_power_kind_select_out <= 1'b1;
            channel_switch_wait_out <= 3'h0;
            bias_current_level_out <= 2'h0;
            conversion_speed_select_out <= 2'h3;
            nominal_rate_sps_out <= SPS_SCAN_3;
        end else begin
            low_power_kind_select_out <= conv_cfg[CC_LOW_POWER_BIT];
            channel_switch_wait_out <= conv_cfg[CC_WAIT_LSB +: 3];
            bias_current_level_out <= conv_cfg[CC_BIAS_LSB +: 2];
            conversion_speed_select_out <= conv_cfg[CC_SPEED_LSB +: 2];
            // Nominal figure; actual rate is lower with wait or chopping
            unique case ({fixed_mode, conv_cfg[CC_SPEED_LSB +: 2]})
                3'b011: nominal_rate_sps_out <= SPS_SCAN_3;
                3'b010: nominal_rate_sps_out <= SPS_SCAN_2;
                3'b001: nominal_rate_sps_out <= SPS_SCAN_1;
                3'b000: nominal_rate_sps_out <= SPS_SCAN_0;
                3'b111: nominal_rate_sps_out <= SPS_FIXED_3;
                3'b110: nominal_rate_sps_out <= SPS_FIXED_2;
                3'b101: nominal_rate_sps_out <= SPS_FIXED_1;
                3'b100: nominal_rate_sps_out <= SPS_FIXED_0;
            endcase
        end
    end

    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            positive_input_select_out <= 4'h0;
            negative_input_select_out <= 4'h0;
            pair_scan_enable_out <= RST_SCAN_PAIR_ENABLES;
            single_input_scan_enable_out <= {RST_SCAN_SINGLE_HIGH_ENABLES, RST_SCAN_SINGLE_LOW_ENABLES};
            monitor_scan_enable_out <= RST_SCAN_MONITOR_ENABLES;
        end else if (fixed_mode) begin
            positive_input_select_out <= regs_q[ADDR_FIXED_CHANNEL_SELECT][FC_POS_LSB +: 4];
            negative_input_select_out <= regs_q[ADDR_FIXED_CHANNEL_SELECT][FC_NEG_LSB +: 4];
            pair_scan_enable_out <= 8'h00;
            single_input_scan_enable_out <= 16'h0000;
            monitor_scan_enable_out <= 8'h00;
        end else begin
            positive_input_select_out <= 4'h0;
            negative_input_select_out <= 4'h0;
            pair_scan_enable_out <= regs_q[ADDR_SCAN_PAIR_ENABLES];
            single_input_scan_enable_out <= {regs_q[ADDR_SCAN_SINGLE_HIGH_ENABLES],
                                             regs_q[ADDR_SCAN_SINGLE_LOW_ENABLES]};
            monitor_scan_enable_out <= regs_q[ADDR_SCAN_MONITOR_ENABLES];
        end
    end

    // ==========================================================
    // Port pins: direction bit 0 drives the pin
    // ==========================================================
    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            port_pin_out <= PORT_WIDTH'(RST_PORT_LEVEL);
            port_pin_oe_n_out <= PORT_WIDTH'(RST_PORT_DIRECTION);
        end else begin
            port_pin_out <= PORT_WIDTH'(regs_q[ADDR_PORT_LEVEL]);
            port_pin_oe_n_out <= PORT_WIDTH'(regs_q[ADDR_PORT_DIRECTION]);
        end
    end

endmodule : acrb_register_bank
